/* File: hw/sba_pkg.sv */
// Constants, register map and state codes for the system bus attachment block.
// Assumes a single 50 MHz clock and a plain register port with byte addresses.
package sba_pkg;

	localparam int NUM_CH     = 3;
	localparam int ADDR_JMP_W = 7;
	localparam int RECOG_W    = 21;
	localparam int LEVELS     = 22;
	localparam int BAUD_JMP_W = 21;
	localparam int NUM_RATES  = 12;
	localparam int CNT_W      = 16;
	localparam int CLK_HZ     = 50_000_000;

	// Register byte offsets.
	localparam logic [7:0] OFF_CMD  = 8'h00;
	localparam logic [7:0] OFF_STAT = 8'h04;
	localparam logic [7:0] OFF_MASK = 8'h08;
	localparam logic [7:0] OFF_BUF  = 8'h0c;
	localparam logic [7:0] OFF_CFG  = 8'h10;

	// Command word fields.
	localparam int CMD_CNT_LSB = 0;
	localparam int CMD_CH_LSB  = 16;

	// Configuration word fields.
	localparam int CFG_ONL_BIT  = 0;
	localparam int CFG_ADDR_LSB = 1;
	localparam int CFG_BAUD_LSB = 8;
	localparam int CFG_LVL_LSB  = 12;

	// Reset values.
	localparam logic [NUM_CH-1:0] MASK_RST = 3'h0;
	localparam logic [31:0]       BUF_RST  = 32'h0;
	localparam logic [3:0]        BAUD_DEFAULT_IDX = 4'h0;

	// Jumper key per rate: first two jumper bytes; bit 8 of the key is a don't care.
	localparam logic [15:0] BAUD_KEY_MASK = 16'hfeff;
	localparam logic [15:0] BAUD_KEY [NUM_RATES] = '{
		16'h1017, 16'h1067, 16'h209e, 16'h4079, 16'h80d7, 16'h80e6,
		16'h02db, 16'h025d, 16'h043a, 16'h04f2, 16'h086c, 16'h0022};
	localparam int BAUD_RATE [NUM_RATES] = '{
		110, 150, 300, 600, 900, 1200, 1800, 2400, 3600, 4800, 7200, 9600};

	// Bus request sequencer states.
	typedef enum logic [2:0] {
		SBA_IDLE = 3'b001,
		SBA_REQ  = 3'b010,
		SBA_XFER = 3'b100
	} sba_bus_st_t;

endpackage

/* File: hw/sba_chan.sv */
// One device channel: its own word buffer, a block counter and a done pulse.
// Assumes the top grants at most one word per cycle and only while busy.
`timescale 1ns/1ps
module sba_chan
	import sba_pkg::*;
#(
	parameter int W = CNT_W
) (
	input  wire logic         clk,
	input  wire logic         rst_n,
	input  wire logic         start,
	input  wire logic [W-1:0] start_cnt,
	input  wire logic [31:0]  start_word,
	input  wire logic         grant,
	output logic              busy,
	output logic              done,
	output logic [31:0]       word
);

	logic [W-1:0] cnt_q;
	logic         busy_q;
	logic         done_q;
	logic [31:0]  word_q;
	logic         last_w;

	if (W < 1) begin : g_chk
		$error("sba_chan: count width must be at least one");
	end

	assign last_w = busy_q && grant && (cnt_q == W'(1));

	// A start while busy is ignored so a running block is never cut short.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_q  <= '0;
			busy_q <= 1'b0;
			done_q <= 1'b0;
			word_q <= BUF_RST;
		end else begin
			done_q <= 1'b0;
			if (start && !busy_q) begin
				cnt_q  <= start_cnt;
				word_q <= start_word;
				busy_q <= (start_cnt != '0);
				done_q <= (start_cnt == '0);
			end else if (busy_q && grant) begin
				cnt_q  <= cnt_q - W'(1);
				busy_q <= !last_w;
				done_q <= last_w;
			end
		end
	end

	assign busy = busy_q;
	assign done = done_q;
	assign word = word_q;

endmodule

/* File: hw/sba_top.sv */
// System bus attachment: address match, buffer register, priority request logic,
// three concurrent block-transfer channels, interrupts and the serial bit-rate tick.
// Assumes all inputs, jumpers included, are synchronous to clk and that the
// register master never issues a read and a write strobe in the same cycle.
`timescale 1ns/1ps
module sba_top
	import sba_pkg::*;
#(
	parameter int CLK_FREQ = CLK_HZ
) (
	input  wire logic                  clk,
	input  wire logic                  resetn,
	// Front-edge switch, high in the on-line position.
	input  wire logic                  online_sw,
	// Low-true address jumpers; bit 6 is the first jumper.
	input  wire logic [ADDR_JMP_W-1:0] addr_jmp_n,
	// Closed (high) recognition jumper per higher level 0..20.
	input  wire logic [RECOG_W-1:0]    recog_jmp,
	// Closed (high) generation jumper selects our level.
	input  wire logic [LEVELS-1:0]     gen_jmp,
	// Bit-rate jumpers.
	input  wire logic [BAUD_JMP_W-1:0] baud_jmp,
	// Requests seen on the bus priority lines, level 0 highest.
	input  wire logic [LEVELS-1:0]     bus_lvl_req,
	// Grant of the bus to this unit.
	input  wire logic                  bus_grant,
	// A word on the bus addressed to some unit.
	input  wire logic                  bus_sel_valid,
	input  wire logic [ADDR_JMP_W-1:0] bus_sel_addr,
	input  wire logic [31:0]           bus_sel_word,
	// Register port.
	input  wire logic [7:0]            reg_addr,
	input  wire logic [31:0]           reg_wdata,
	input  wire logic                  reg_wr,
	input  wire logic                  reg_rd,
	output logic [31:0]                reg_rdata,
	// Bus side outputs.
	output logic                       bus_ack,
	output logic [LEVELS-1:0]          bus_req,
	output logic                       bus_xfer_valid,
	output logic [1:0]                 bus_xfer_chan,
	output logic [31:0]                bus_xfer_word,
	// Interrupt and serial bit-rate tick.
	output logic                       irq,
	output logic                       baud_tick
);

	// The bit-period counter needs at least two clocks per bit at the top rate.
	if (CLK_FREQ / BAUD_RATE[NUM_RATES-1] < 2) begin : g_chk
		$error("sba_top: clock too slow for the fastest bit rate");
	end

	// The command word names a channel in two bits, so no more than four fit.
	if (NUM_CH > 4) begin : g_chk_ch
		$error("sba_top: more channels than the command field can name");
	end

	// Count and channel fields must both sit inside one 32-bit command word.
	if (CMD_CH_LSB + 2 > 32 || CNT_W > CMD_CH_LSB) begin : g_chk_cmd
		$error("sba_top: command word fields overlap or overflow");
	end

	// Recognition covers only the levels above ours, so it is the narrower set.
	if (RECOG_W >= LEVELS) begin : g_chk_lvl
		$error("sba_top: recognition set must be narrower than the level set");
	end

	// The own-level field of the configuration word is five bits wide.
	if (LEVELS > 31) begin : g_chk_fld
		$error("sba_top: too many levels for the configuration field");
	end

	// The rate index travels in four bits.
	if (NUM_RATES > 16) begin : g_chk_rate
		$error("sba_top: too many bit rates for the index field");
	end

	// Reset release through two flops; assertion stays asynchronous.
	// The first flop may go metastable on release, so only the second is used.
	logic rst_meta_q;
	logic rst_n_q;

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			rst_meta_q <= 1'b0;
			rst_n_q    <= 1'b0;
		end else begin
			rst_meta_q <= 1'b1;
			rst_n_q    <= rst_meta_q;
		end
	end

	// Declarations: jumper decode and bit-rate selection first.
	logic [ADDR_JMP_W-1:0] my_addr_w;
	logic                  addr_hit_w;
	logic                  inhibit_w;
	logic [4:0]            own_lvl_w;
	logic [3:0]            baud_idx_w;
	logic [15:0]           baud_key_w;
	logic [31:0]           baud_div_w;

	// Register port decode and the channel handshakes.
	logic                  wr_cmd_w;
	logic                  wr_mask_w;
	logic                  wr_buf_w;
	logic                  rd_stat_w;
	logic [31:0]           rd_mux_w;
	logic [1:0]            cmd_ch_w;
	logic [CNT_W-1:0]      cmd_cnt_w;

	logic [NUM_CH-1:0]     ch_start_w;
	logic [NUM_CH-1:0]     ch_grant_w;
	logic [NUM_CH-1:0]     ch_busy_w;
	logic [NUM_CH-1:0]     ch_done_w;
	logic [31:0]           ch_word_w [NUM_CH];
	logic [1:0]            pick_w;

	// Flops and the next-state nets that feed them.
	logic [31:0]           buf_q;
	logic [31:0]           buf_d;
	logic [NUM_CH-1:0]     stat_q;
	logic [NUM_CH-1:0]     stat_d;
	logic [NUM_CH-1:0]     mask_q;
	logic [31:0]           rdata_q;
	logic                  ack_q;
	logic [LEVELS-1:0]     req_q;
	logic                  xv_q;
	logic [1:0]            xch_q;
	logic [1:0]            cur_q;
	logic [31:0]           xword_q;
	logic                  irq_q;
	logic [31:0]           bcnt_q;
	logic                  btick_q;
	sba_bus_st_t           st_q;
	sba_bus_st_t           st_d;

	// Address jumpers are low-true, so a closed jumper reads as a one bit.
	// Only an on-line unit matches, so an off-line unit neither acknowledges nor captures a bus word.
	assign my_addr_w  = ~addr_jmp_n;
	assign addr_hit_w = online_sw && bus_sel_valid && (bus_sel_addr == my_addr_w);

	// Any closed recognition jumper whose level is requesting holds us off.
	// Our own and lower levels are never looked at, relying on open jumpers there.
	assign inhibit_w = |(recog_jmp & bus_lvl_req[RECOG_W-1:0]);

	// Our level number, for the configuration read: the lowest closed generation jumper.
	always_comb begin
		own_lvl_w = 5'h1f;
		for (int i = LEVELS - 1; i >= 0; i--) begin
			if (gen_jmp[i]) begin
				own_lvl_w = 5'(i);
			end
		end
	end

	// Bit-rate selection. Unknown jumper patterns fall back to the default rate
	// rather than stopping the tick, so a misjumpered card still talks slowly.
	// The key is the first two jumper bytes; its bit 8 is a don't-care position.
	assign baud_key_w = {baud_jmp[20:14], 1'b0, baud_jmp[13:6]};

	// Index of the matching key; the last match wins, though keys never overlap.
	always_comb begin
		baud_idx_w = BAUD_DEFAULT_IDX;
		for (int i = 0; i < NUM_RATES; i++) begin
			if ((baud_key_w & BAUD_KEY_MASK) == (BAUD_KEY[i] & BAUD_KEY_MASK)) begin
				baud_idx_w = 4'(i);
			end
		end
	end

	// Divider per rate, fixed at elaboration. Integer division rounds down, which
	// keeps the error under one clock per bit, far inside a receiver's margin.
	always_comb begin
		baud_div_w = 32'(CLK_FREQ / BAUD_RATE[0]);
		for (int i = 0; i < NUM_RATES; i++) begin
			if (baud_idx_w == 4'(i)) begin
				baud_div_w = 32'(CLK_FREQ / BAUD_RATE[i]);
			end
		end
	end

	// Free-running bit-period counter; one pulse per bit time.
	always_ff @(posedge clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			bcnt_q  <= 32'h0;
			btick_q <= 1'b0;
		end else if (bcnt_q >= baud_div_w - 32'h1) begin
			bcnt_q  <= 32'h0;
			btick_q <= 1'b1;
		end else begin
			bcnt_q  <= bcnt_q + 32'h1;
			btick_q <= 1'b0;
		end
	end

	// Register decode. Commands are ignored while off-line, but the mask and
	// the buffer stay writable so software can prepare a unit before it goes
	// on-line again.
	assign wr_cmd_w  = reg_wr && (reg_addr == OFF_CMD) && online_sw;
	assign wr_mask_w = reg_wr && (reg_addr == OFF_MASK);
	assign wr_buf_w  = reg_wr && (reg_addr == OFF_BUF);
	assign rd_stat_w = reg_rd && (reg_addr == OFF_STAT);
	assign cmd_ch_w  = reg_wdata[CMD_CH_LSB +: 2];
	assign cmd_cnt_w = reg_wdata[CMD_CNT_LSB +: CNT_W];

	// Unmapped addresses read as zero.
	// A status read shows the bits as they were before its own clear.
	always_comb begin
		rd_mux_w = 32'h0;
		case (reg_addr)
			OFF_CMD:  rd_mux_w = 32'(ch_busy_w);
			OFF_STAT: rd_mux_w = 32'(stat_q);
			OFF_MASK: rd_mux_w = 32'(mask_q);
			OFF_BUF:  rd_mux_w = buf_q;
			OFF_CFG: begin
				rd_mux_w[CFG_ONL_BIT]                 = online_sw;
				rd_mux_w[CFG_ADDR_LSB +: ADDR_JMP_W] = my_addr_w;
				rd_mux_w[CFG_BAUD_LSB +: 4]          = baud_idx_w;
				rd_mux_w[CFG_LVL_LSB +: 5]           = own_lvl_w;
			end
			default:  rd_mux_w = 32'h0;
		endcase
	end

	// Buffer register. A bus word addressed to us wins over a software write
	// in the same cycle, since the bus cannot be told to retry.
	assign buf_d = addr_hit_w ? bus_sel_word : (wr_buf_w ? reg_wdata : buf_q);

	always_ff @(posedge clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			buf_q <= BUF_RST;
			ack_q <= 1'b0;
		end else begin
			buf_q <= buf_d;
			ack_q <= addr_hit_w;
		end
	end

	// Channels. A command copies the buffer word into the chosen channel.
	// A channel field that names no channel starts nothing, and a command
	// for a busy channel is dropped inside the channel itself.
	for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
		assign ch_start_w[c] = wr_cmd_w && (cmd_ch_w == 2'(c));
		assign ch_grant_w[c] = (st_q == SBA_XFER) && (cur_q == 2'(c));

		sba_chan #(
			.W(CNT_W)
		) u_chan (
			.clk        (clk),
			.rst_n      (rst_n_q),
			.start      (ch_start_w[c]),
			.start_cnt  (cmd_cnt_w),
			.start_word (buf_q),
			.grant      (ch_grant_w[c]),
			.busy       (ch_busy_w[c]),
			.done       (ch_done_w[c]),
			.word       (ch_word_w[c])
		);
	end

	// Fixed order among channels when several want the bus; each word is a
	// separate request, so no channel can hold the bus past one transfer.
	assign pick_w = ch_busy_w[0] ? 2'd0 : (ch_busy_w[1] ? 2'd1 : 2'd2);

	// Bus request sequencer. One grant moves one word, and the sequencer goes
	// back to idle after every word so that a channel of higher fixed rank can
	// step in between two words of a long block.
	always_comb begin
		st_d = st_q;
		case (st_q)
			SBA_IDLE: begin
				if (online_sw && |ch_busy_w) begin
					st_d = SBA_REQ;
				end
			end
			SBA_REQ: begin
				if (!online_sw) begin
					st_d = SBA_IDLE;
				end else if (bus_grant && !inhibit_w) begin
					st_d = SBA_XFER;
				end
			end
			SBA_XFER: st_d = SBA_IDLE;
			default:  st_d = SBA_IDLE;
		endcase
	end

	// State and the channel being served. The choice is frozen outside idle so
	// a word always goes out for the channel that won the request.
	always_ff @(posedge clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			st_q  <= SBA_IDLE;
			cur_q <= 2'd0;
		end else begin
			st_q <= st_d;
			if (st_q == SBA_IDLE) begin
				cur_q <= pick_w;
			end
		end
	end

	// Request drives only our generation level, and only while not inhibited.
	// Being registered, it drops one cycle after a higher level shows up.
	always_ff @(posedge clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			req_q   <= '0;
			xv_q    <= 1'b0;
			xch_q   <= 2'd0;
			xword_q <= 32'h0;
		end else begin
			req_q <= (st_d == SBA_REQ && !inhibit_w) ? gen_jmp : '0;
			xv_q  <= (st_q == SBA_XFER);
			if (st_q == SBA_XFER) begin
				xch_q   <= cur_q;
				xword_q <= ch_word_w[cur_q];
			end
		end
	end

	// Interrupts: sticky done bits, cleared by reading status; a done that
	// lands in the clearing cycle survives.
	assign stat_d = (rd_stat_w ? '0 : stat_q) | ch_done_w;

	always_ff @(posedge clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			stat_q  <= '0;
			mask_q  <= MASK_RST;
			irq_q   <= 1'b0;
			rdata_q <= 32'h0;
		end else begin
			stat_q <= stat_d;
			if (wr_mask_w) begin
				mask_q <= reg_wdata[NUM_CH-1:0];
			end
			irq_q   <= online_sw && |(stat_d & mask_q);
			rdata_q <= reg_rd ? rd_mux_w : 32'h0;
		end
	end

	// Outputs straight from flops, so the far side never sees decode glitches.
	// Read data stay zero outside the answer cycle, so several ports can be ORed.
	assign reg_rdata      = rdata_q;
	assign bus_ack        = ack_q;
	assign bus_req        = req_q;
	assign bus_xfer_valid = xv_q;
	assign bus_xfer_chan  = xch_q;
	assign bus_xfer_word  = xword_q;
	assign irq            = irq_q;
	assign baud_tick      = btick_q;

endmodule

/* File: tb/sba_top_chk.sv */
// Checker for the bus attachment top: bus answers, priority request, interrupt.
// Assumes it is bound to sba_top and sees only that module's ports.
`timescale 1ns/1ps
module sba_top_chk
	import sba_pkg::*;
(
	input wire logic                  clk,
	input wire logic                  resetn,
	input wire logic                  online_sw,
	input wire logic [ADDR_JMP_W-1:0] addr_jmp_n,
	input wire logic [RECOG_W-1:0]    recog_jmp,
	input wire logic [LEVELS-1:0]     gen_jmp,
	input wire logic [LEVELS-1:0]     bus_lvl_req,
	input wire logic                  bus_grant,
	input wire logic                  bus_sel_valid,
	input wire logic [ADDR_JMP_W-1:0] bus_sel_addr,
	input wire logic                  reg_rd,
	input wire logic [31:0]           reg_rdata,
	input wire logic                  bus_ack,
	input wire logic [LEVELS-1:0]     bus_req,
	input wire logic                  bus_xfer_valid,
	input wire logic                  irq
);
	// A word for us, and a closed higher level that is requesting.
	wire logic hit     = bus_sel_valid && online_sw && (bus_sel_addr == ~addr_jmp_n);
	wire logic inhibit = |(recog_jmp & bus_lvl_req[RECOG_W-1:0]);

	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);

	chk_ack_on_hit: assert property (hit |=> bus_ack)
		else $error("no ack after an address hit");
	chk_ack_has_cause: assert property (bus_ack |-> $past(hit))
		else $error("ack without a hit");
	chk_req_own_level: assert property (bus_req != '0 |-> bus_req == gen_jmp)
		else $error("request on a wrong level");
	chk_req_inhibit: assert property (inhibit |=> bus_req == '0)
		else $error("request kept under a higher request");
	chk_offline_quiet: assert property (!online_sw ##1 !online_sw
		|-> !bus_ack && bus_req == '0 && !irq)
		else $error("activity while off-line");
	chk_xfer_one_cycle: assert property (bus_xfer_valid |=> !bus_xfer_valid)
		else $error("word pulse longer than one cycle");
	chk_xfer_after_grant: assert property (bus_xfer_valid
		|-> $past(bus_grant && !inhibit, 2))
		else $error("word sent without a clean grant");
	chk_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == '0)
		else $error("read data outside its cycle");
	chk_irq_online: assert property (irq |-> $past(online_sw))
		else $error("interrupt while off-line");
endmodule

bind sba_top sba_top_chk u_chk (.clk(clk), .resetn(resetn), .online_sw(online_sw),
	.addr_jmp_n(addr_jmp_n), .recog_jmp(recog_jmp), .gen_jmp(gen_jmp),
	.bus_lvl_req(bus_lvl_req), .bus_grant(bus_grant), .bus_sel_valid(bus_sel_valid),
	.bus_sel_addr(bus_sel_addr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
	.bus_ack(bus_ack), .bus_req(bus_req), .bus_xfer_valid(bus_xfer_valid), .irq(irq));

/* File: tb/sba_bus_peer.sv */
// Model of the other bus modules, the terminator and a slow arbiter.
// Assumes level 0 is the highest priority and one grant serves one word.
`timescale 1ns/1ps
module sba_bus_peer
	import sba_pkg::*;
(
	input  wire logic              clk,
	input  wire logic [LEVELS-1:0] bus_req,
	input  wire logic [LEVELS-1:0] other_req,
	input  wire logic [3:0]        delay,
	output logic                   bus_grant,
	output logic [LEVELS-1:0]      bus_lvl_req
);
	localparam logic [LEVELS-1:0] ASSIGNED = 22'h000124;
	logic [3:0] wait_q;
	logic       higher;

	// Levels 2, 5 and 8 are installed; the terminator keeps the rest quiet.
	assign bus_lvl_req = other_req & ASSIGNED;
	assign higher      = |(bus_lvl_req & (bus_req - 22'h1));

	// Grant for one cycle once the request has stood for the delay; a vanished
	// request is never granted, and a higher requester always wins.
	always_ff @(posedge clk) begin
		if (bus_req == '0 || bus_grant) begin
			wait_q    <= 4'h0;
			bus_grant <= 1'b0;
		end else begin
			wait_q    <= wait_q + 4'h1;
			bus_grant <= (wait_q >= delay) && !higher;
		end
	end
endmodule

/* File: tb/testbench.sv */
// Self-checking bench for the bus attachment top with a model of the bus peers.
// Assumes the register port answers one cycle after a read strobe.
`timescale 1ns/1ps
module testbench;
	import sba_pkg::*;
	localparam int FREQ = 96000;
	logic              clk, resetn, online_sw, bus_sel_valid, reg_wr, reg_rd;
	logic [6:0]        addr_jmp_n, bus_sel_addr;
	logic [20:0]       recog_jmp, baud_jmp;
	logic [21:0]       gen_jmp, other_req, bus_lvl_req, bus_req;
	logic [31:0]       bus_sel_word, reg_wdata, reg_rdata, bus_xfer_word, last_word;
	logic [7:0]        reg_addr;
	logic [3:0]        peer_delay;
	logic [1:0]        bus_xfer_chan;
	logic              bus_grant, bus_ack, bus_xfer_valid, irq, baud_tick;
	int                xfers [3] = '{0, 0, 0};
	int                checks = 0, miscompares = 0, cycles = 0;

	sba_top #(.CLK_FREQ(FREQ)) u_dut (.clk(clk), .resetn(resetn), .online_sw(online_sw),
		.addr_jmp_n(addr_jmp_n), .recog_jmp(recog_jmp), .gen_jmp(gen_jmp),
		.baud_jmp(baud_jmp), .bus_lvl_req(bus_lvl_req), .bus_grant(bus_grant),
		.bus_sel_valid(bus_sel_valid), .bus_sel_addr(bus_sel_addr),
		.bus_sel_word(bus_sel_word), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .bus_ack(bus_ack),
		.bus_req(bus_req), .bus_xfer_valid(bus_xfer_valid), .bus_xfer_chan(bus_xfer_chan),
		.bus_xfer_word(bus_xfer_word), .irq(irq), .baud_tick(baud_tick));
	sba_bus_peer u_peer (.clk(clk), .bus_req(bus_req), .other_req(other_req),
		.delay(peer_delay), .bus_grant(bus_grant), .bus_lvl_req(bus_lvl_req));

	// Free-running clock.
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	// Count words per channel; a stray channel number is simply dropped.
	always @(posedge clk) begin
		if (bus_xfer_valid === 1'b1) begin
			xfers[bus_xfer_chan]++;
			last_word = bus_xfer_word;
		end
	end

	// A hang is cut short well beyond the longest expected run.
	always @(posedge clk) begin
		cycles++;
		if (cycles == 30000) begin
			miscompares++;
			give_verdict();
		end
	end

	task automatic give_verdict();
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		checks++;
		if (got !== exp) begin
			miscompares++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic settle(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string what);
		@(posedge clk);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1;
		check(what, exp, reg_rdata);
	endtask

	task automatic bus_word(input logic [6:0] a, input logic [31:0] w, input logic ack);
		@(posedge clk);
		bus_sel_valid <= 1'b1;
		bus_sel_addr  <= a;
		bus_sel_word  <= w;
		@(posedge clk);
		bus_sel_valid <= 1'b0;
		#1;
		check("bus_ack", 32'(ack), 32'(bus_ack));
	endtask

	task automatic wait_words(input int ch, input int n);
		for (int i = 0; i < 600 && xfers[ch] < n; i++)
			@(posedge clk);
		check("words sent", n, xfers[ch]);
	endtask

	// Ticks must come every FREQ/rate cycles, within one cycle of rounding.
	task automatic tick_period(input int rate);
		int n;
		n = 0;
		for (int i = 0; i < 2000 && baud_tick !== 1'b1; i++)
			settle(1);
		do begin
			settle(1);
			n++;
		end while (baud_tick !== 1'b1 && n < 2000);
		check("tick period ok", 1, 32'(n >= FREQ / rate - 1 && n <= FREQ / rate + 1));
	endtask

	function automatic logic [20:0] jmp_of(input logic [15:0] k);
		return {k[15:9], k[7:0], 6'h0};
	endfunction

	function automatic logic [31:0] cfg(input logic [3:0] idx, input logic onl);
		return {15'h0, 5'd5, idx, 7'h25, onl};
	endfunction

	// Main sequence: own level 5, levels 0..4 closed for recognition.
	initial begin
		resetn = 1'b0;
		online_sw = 1'b1;
		addr_jmp_n = 7'h5a;
		recog_jmp = 21'h1f;
		gen_jmp = 22'h20;
		baud_jmp = jmp_of(BAUD_KEY[11]);
		other_req = '0;
		peer_delay = 4'h3;
		bus_sel_valid = 1'b0;
		bus_sel_addr = '0;
		bus_sel_word = '0;
		reg_addr = '0;
		reg_wdata = '0;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		repeat (20) @(posedge clk);
		resetn <= 1'b1;
		repeat (3) @(posedge clk);
		rd(OFF_MASK, {29'h0, MASK_RST}, "mask");
		rd(8'h20, 32'h0, "unmapped");
		rd(OFF_BUF, BUF_RST, "buffer");
		rd(OFF_CFG, cfg(4'hb, 1'b1), "config");
		bus_word(7'h25, 32'hcafe0001, 1'b1);
		bus_word(7'h5a, 32'h0bad0bad, 1'b0);
		bus_word(7'h24, 32'h0bad0bad, 1'b0);
		rd(OFF_BUF, 32'hcafe0001, "buffer");
		wr(OFF_BUF, 32'h1234abcd);
		rd(OFF_BUF, 32'h1234abcd, "buffer");
		// Two-word block with a lower level busy on the bus.
		wr(OFF_MASK, 32'h1);
		other_req <= 22'h100;
		wr(OFF_CMD, {14'h0, 2'd0, 16'd2});
		rd(OFF_CMD, 32'h1, "busy");
		wait_words(0, 2);
		check("word", 32'h1234abcd, last_word);
		settle(4);
		check("irq", 1, 32'(irq));
		@(posedge clk);
		online_sw <= 1'b0;
		settle(3);
		check("irq off-line", 0, 32'(irq));
		bus_word(7'h25, 32'h0bad0bad, 1'b0);
		rd(OFF_BUF, 32'h1234abcd, "buffer off-line");
		wr(OFF_CMD, {14'h0, 2'd1, 16'd1});
		rd(OFF_CMD, 32'h0, "busy off-line");
		rd(OFF_CFG, cfg(4'hb, 1'b0), "config");
		@(posedge clk);
		online_sw <= 1'b1;
		settle(3);
		check("irq on-line", 1, 32'(irq));
		rd(OFF_STAT, 32'h1, "status");
		rd(OFF_STAT, 32'h0, "status");
		settle(2);
		check("irq", 0, 32'(irq));
		// A closed higher level holds our request back.
		@(posedge clk);
		other_req <= 22'h4;
		wr(OFF_CMD, {14'h0, 2'd2, 16'd1});
		settle(20);
		check("req held", 0, 32'(bus_req));
		check("words held", 0, xfers[2]);
		@(posedge clk);
		other_req <= '0;
		wait_words(2, 1);
		// Two channels at once, masked off, then a refused channel number.
		peer_delay <= 4'h8;
		wr(OFF_MASK, 32'h0);
		wr(OFF_CMD, {14'h0, 2'd1, 16'd1});
		wr(OFF_CMD, {14'h0, 2'd2, 16'd3});
		rd(OFF_CMD, 32'h6, "busy both");
		wait_words(1, 1);
		wait_words(2, 4);
		settle(3);
		check("irq masked", 0, 32'(irq));
		wr(OFF_MASK, 32'h4);
		settle(3);
		check("irq ch2", 1, 32'(irq));
		rd(OFF_STAT, 32'h6, "status");
		wr(OFF_CMD, {14'h0, 2'd3, 16'd1});
		rd(OFF_CMD, 32'h0, "busy ch3");
		wr(OFF_CMD, {14'h0, 2'd0, 16'd0});
		settle(4);
		rd(OFF_STAT, 32'h1, "zero count");
		check("zero words", 2, xfers[0]);
		// Bit rates: every key, an unmatched key, and two tick periods.
		tick_period(9600);
		for (int i = 0; i < NUM_RATES; i++) begin
			@(posedge clk);
			baud_jmp <= jmp_of(BAUD_KEY[i]);
			rd(OFF_CFG, cfg(4'(i), 1'b1), "rate index");
		end
		@(posedge clk);
		baud_jmp <= '0;
		rd(OFF_CFG, cfg(4'h0, 1'b1), "rate index");
		tick_period(110);
		give_verdict();
	end
endmodule
